// ===== rtl/hmtc_pkg.sv
// package: register map, field positions, reset values and mode codes for the mode-control block
package hmtc_pkg;
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_MODE = 8'h01;
    localparam logic [7:0] OFF_AMPL = 8'h02;
    localparam logic [7:0] OFF_LAUNCH = 8'h0c;
    localparam logic [7:0] OFF_FORMAT = 8'h1d;
    localparam logic [7:0] OFF_INCTL = 8'h20;
    localparam int BIT_SOFT_RESET = 7;
    localparam int BIT_STANDBY = 6;
    localparam int BIT_CHECK = 3;
    localparam int BIT_LAUNCH = 0;
    localparam int BIT_UNSIGNED = 3;
    localparam int BIT_ANALOG = 0;
    localparam int BIT_BIAS = 1;
    localparam logic [7:0] MODE_RESET = 8'h40;
    localparam logic [7:0] AMPL_RESET = 8'h00;
    localparam logic [2:0] DEVICE_CODE = 3'h5; // arbitrary value
    localparam logic [7:0] ROUTINE_CYCLES = 8'h10;
    localparam logic [1:0] RESET_CYCLES = 2'h3;

    typedef enum logic [2:0] {
        HMTC_M_INTERNAL = 3'b000,
        HMTC_M_EDGE = 3'b001,
        HMTC_M_LEVEL = 3'b010,
        HMTC_M_PWM = 3'b011,
        HMTC_M_AUDIO = 3'b100,
        HMTC_M_STREAM = 3'b101,
        HMTC_M_DIAG = 3'b110,
        HMTC_M_CAL = 3'b111
    } hmtc_mode_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } hmtc_req_t;

    typedef struct packed {
        logic active;
        logic use_pin;
        logic analog;
        logic audio;
        logic stream;
        logic [8:0] level;
    } hmtc_drive_t;
endpackage : hmtc_pkg

// ===== rtl/hmtc_sync.sv
// two-flop synchroniser with rising and falling edge pulses taken from the settled copy
module hmtc_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic d_i,
    output logic q_o,
    output logic rise_o,
    output logic fall_o
);
    logic meta;
    logic sync;
    logic last;
    logic next_meta;
    logic next_sync;
    logic next_last;

    always_comb begin
        next_meta = d_i;
        next_sync = meta;
        next_last = sync;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta <= 1'b0;
            sync <= 1'b0;
            last <= 1'b0;
        end else begin
            meta <= next_meta;
            sync <= next_sync;
            last <= next_last;
        end
    end

    assign q_o = sync;
    assign rise_o = sync & ~last;
    assign fall_o = ~sync & last;
endmodule : hmtc_sync

// ===== rtl/hmtc_top.sv
// mode-control register, trigger handling, soft reset and routine sequencing
// Contract
// - soft-reset bit 7 acts as power cycle
// - soft reset stops playback, restores defaults
// - soft-reset bit self-clears when done, resets 0
// - standby bit 6 resets to 1
// - mode bits 2-0; mode 0 launches by software
// - mode 1: pin rising edge sets launch
// - mode 1: second edge while launched cancels
// - level mode: launch follows pin
// - level mode: redundant edge changes nothing
// - mode 3: pin drives actuator, pwm/analog select
// - mode 4: audio on pin drives vibration
// - mode 5: drive from streamed amplitude register
// - mode 6: launch runs diagnostic, stores outcome
// - mode 7: launch runs calibration, self-clears
// - outcome bit: 1 fail, clears on read
// - streamed value signed unless unsigned bit set
module hmtc_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire hmtc_pkg::hmtc_req_t req_i,
    input wire logic shared_stimulus_pin_i,
    input wire logic routine_fail_i,
    output logic [7:0] rdata_o,
    output logic launch_o,
    output logic cancel_o,
    output logic standby_o,
    output logic routine_busy_o,
    output hmtc_pkg::hmtc_drive_t drive_o
);
    import hmtc_pkg::*;

    logic pin_q;
    logic pin_rise;
    logic pin_fall;

    hmtc_sync u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(shared_stimulus_pin_i),
        .q_o(pin_q),
        .rise_o(pin_rise),
        .fall_o(pin_fall)
    );

    // register state
    logic soft_reset;
    logic standby;
    hmtc_mode_t mode;
    logic [7:0] streamed_amplitude_value;
    logic unsigned_format_select;
    logic analog_select;
    logic audio_bias_enable;
    logic launch;
    logic check_outcome_bit;
    logic cancel;
    logic [7:0] routine_cnt;
    logic [1:0] reset_cnt;
    logic [7:0] rdata;
    hmtc_drive_t drive;
    logic busy;

    logic next_soft_reset;
    logic next_standby;
    hmtc_mode_t next_mode;
    logic [7:0] next_ampl;
    logic next_unsigned;
    logic next_analog;
    logic next_bias;
    logic next_launch;
    logic next_check;
    logic next_cancel;
    logic [7:0] next_routine_cnt;
    logic [1:0] next_reset_cnt;
    logic [7:0] next_rdata;
    hmtc_drive_t next_drive;
    logic next_busy;

    logic wr_mode;
    logic routine_mode;
    logic routine_done;

    assign wr_mode = req_i.wr && req_i.addr == OFF_MODE;
    assign routine_mode = mode == HMTC_M_DIAG || mode == HMTC_M_CAL;
    assign routine_done = routine_mode && launch && routine_cnt == 8'h01;

    always_comb begin
        next_soft_reset = soft_reset;
        next_standby = standby;
        next_mode = mode;
        next_ampl = streamed_amplitude_value;
        next_unsigned = unsigned_format_select;
        next_analog = analog_select;
        next_bias = audio_bias_enable;
        next_launch = launch;
        next_check = check_outcome_bit;
        next_cancel = 1'b0;
        next_routine_cnt = routine_cnt;
        next_reset_cnt = reset_cnt;
        next_rdata = rdata;
        if (soft_reset) begin
            // hold every register at its default while the reset runs, then let the bit drop
            next_standby = MODE_RESET[BIT_STANDBY];
            next_mode = hmtc_mode_t'(MODE_RESET[2:0]);
            next_ampl = AMPL_RESET;
            next_unsigned = 1'b0;
            next_analog = 1'b0;
            next_bias = 1'b0;
            next_launch = 1'b0;
            next_check = 1'b0;
            next_routine_cnt = 8'h00;
            next_rdata = 8'h00;
            if (reset_cnt == 2'h0) begin
                next_soft_reset = 1'b0;
            end else begin
                next_reset_cnt = reset_cnt - 2'h1;
            end
        end else begin
            if (req_i.rd) begin
                case (req_i.addr)
                    OFF_STATUS: begin
                        next_rdata = {DEVICE_CODE, 1'b0, check_outcome_bit, 3'b000};
                        next_check = 1'b0;
                    end
                    OFF_MODE: next_rdata = {soft_reset, standby, 3'b000, mode};
                    OFF_AMPL: next_rdata = streamed_amplitude_value;
                    OFF_LAUNCH: next_rdata = {7'h00, launch};
                    OFF_FORMAT: next_rdata = {4'h0, unsigned_format_select, 3'b000};
                    OFF_INCTL: next_rdata = {6'h00, audio_bias_enable, analog_select};
                    default: next_rdata = 8'h00;
                endcase
            end
            if (req_i.wr) begin
                case (req_i.addr)
                    OFF_MODE: begin
                        next_standby = req_i.wdata[BIT_STANDBY];
                        next_mode = hmtc_mode_t'(req_i.wdata[2:0]);
                        if (req_i.wdata[BIT_SOFT_RESET]) begin
                            // defaults take hold at once so the mode from this write never runs
                            next_standby = MODE_RESET[BIT_STANDBY];
                            next_mode = hmtc_mode_t'(MODE_RESET[2:0]);
                            next_soft_reset = 1'b1;
                            next_reset_cnt = RESET_CYCLES;
                            next_launch = 1'b0;
                            next_cancel = launch;
                        end
                    end
                    OFF_AMPL: next_ampl = req_i.wdata;
                    OFF_FORMAT: next_unsigned = req_i.wdata[BIT_UNSIGNED];
                    OFF_INCTL: begin
                        next_analog = req_i.wdata[BIT_ANALOG];
                        next_bias = req_i.wdata[BIT_BIAS];
                    end
                    OFF_LAUNCH: begin
                        // software launch works in every mode; clearing it cancels
                        if (req_i.wdata[BIT_LAUNCH] && !launch) begin
                            next_launch = 1'b1;
                            next_routine_cnt = ROUTINE_CYCLES;
                        end else if (!req_i.wdata[BIT_LAUNCH] && launch) begin
                            next_launch = 1'b0;
                            next_cancel = 1'b1;
                        end
                    end
                    default: ;
                endcase
            end
            if (!(wr_mode && req_i.wdata[BIT_SOFT_RESET])) begin
                case (mode)
                    HMTC_M_EDGE: begin
                        if (pin_rise && !launch) begin
                            next_launch = 1'b1;
                        end else if (pin_rise && launch) begin
                            next_launch = 1'b0;
                            next_cancel = 1'b1;
                        end
                    end
                    HMTC_M_LEVEL: begin
                        // edges that match the current launch state are ignored
                        if (pin_rise && !launch) begin
                            next_launch = 1'b1;
                        end else if (pin_fall && launch) begin
                            next_launch = 1'b0;
                            next_cancel = 1'b1;
                        end
                    end
                    HMTC_M_DIAG, HMTC_M_CAL: begin
                        if (launch && routine_cnt != 8'h00) begin
                            next_routine_cnt = routine_cnt - 8'h01;
                        end
                        if (routine_done) begin
                            next_launch = 1'b0;
                            // set wins over a read-clear in the same cycle
                            next_check = routine_fail_i;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    always_comb begin
        next_drive.active = !next_soft_reset && !next_standby && (next_mode == HMTC_M_PWM ||
            next_mode == HMTC_M_AUDIO || next_mode == HMTC_M_STREAM || next_launch);
        next_drive.use_pin = next_mode == HMTC_M_PWM || next_mode == HMTC_M_AUDIO;
        next_drive.analog = next_analog;
        next_drive.audio = next_mode == HMTC_M_AUDIO;
        next_drive.stream = next_mode == HMTC_M_STREAM;
        next_busy = next_launch && (next_mode == HMTC_M_DIAG || next_mode == HMTC_M_CAL);
        // signed by default; unsigned values are zero-extended into the 9-bit level
        if (next_unsigned) begin
            next_drive.level = {1'b0, next_ampl};
        end else begin
            next_drive.level = {next_ampl[7], next_ampl};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            soft_reset <= 1'b0;
            standby <= MODE_RESET[BIT_STANDBY];
            mode <= HMTC_M_INTERNAL;
            streamed_amplitude_value <= AMPL_RESET;
            unsigned_format_select <= 1'b0;
            analog_select <= 1'b0;
            audio_bias_enable <= 1'b0;
            launch <= 1'b0;
            check_outcome_bit <= 1'b0;
            cancel <= 1'b0;
            routine_cnt <= 8'h00;
            reset_cnt <= 2'h0;
            rdata <= 8'h00;
            drive <= '0;
            busy <= 1'b0;
        end else begin
            soft_reset <= next_soft_reset;
            standby <= next_standby;
            mode <= next_mode;
            streamed_amplitude_value <= next_ampl;
            unsigned_format_select <= next_unsigned;
            analog_select <= next_analog;
            audio_bias_enable <= next_bias;
            launch <= next_launch;
            check_outcome_bit <= next_check;
            cancel <= next_cancel;
            routine_cnt <= next_routine_cnt;
            reset_cnt <= next_reset_cnt;
            rdata <= next_rdata;
            drive <= next_drive;
            busy <= next_busy;
        end
    end

    assign rdata_o = rdata;
    assign launch_o = launch;
    assign cancel_o = cancel;
    assign standby_o = standby;
    assign routine_busy_o = busy;
    assign drive_o = drive;

    a_reset_clears: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(soft_reset) |-> ##[1:5] !soft_reset)
        else $error("soft reset did not clear");
    a_reset_defaults: assert property (@(posedge clk_i) disable iff (rst_i)
        soft_reset && $past(soft_reset) |-> standby && mode == HMTC_M_INTERNAL && !launch)
        else $error("defaults not held in soft reset");
    a_edge_launch: assert property (@(posedge clk_i) disable iff (rst_i)
        mode == HMTC_M_EDGE && pin_rise && !launch && !req_i.wr && !soft_reset |=> launch)
        else $error("edge did not launch");
    a_edge_cancel: assert property (@(posedge clk_i) disable iff (rst_i)
        mode == HMTC_M_EDGE && pin_rise && launch && !req_i.wr && !soft_reset |=> !launch && cancel)
        else $error("second edge did not cancel");
    a_level_follow: assert property (@(posedge clk_i) disable iff (rst_i)
        mode == HMTC_M_LEVEL && pin_fall && launch && !req_i.wr && !soft_reset |=> !launch && cancel)
        else $error("falling edge did not cancel");
    a_level_noop: assert property (@(posedge clk_i) disable iff (rst_i)
        mode == HMTC_M_LEVEL && pin_fall && !launch && !req_i.wr && !soft_reset |=> !launch && !cancel)
        else $error("redundant edge changed state");
    a_routine_ends: assert property (@(posedge clk_i) disable iff (rst_i)
        routine_mode && $rose(launch) && !req_i.wr |-> ##[1:17] !launch)
        else $error("routine did not self-clear");
    a_outcome_read: assert property (@(posedge clk_i) disable iff (rst_i)
        req_i.rd && req_i.addr == OFF_STATUS && !routine_done && !soft_reset |=> !check_outcome_bit)
        else $error("outcome not cleared on read");
    a_stream_level: assert property (@(posedge clk_i) disable iff (rst_i)
        drive.stream && !unsigned_format_select && $stable(streamed_amplitude_value) && !$past(soft_reset)
        |-> drive.level[8] == streamed_amplitude_value[7])
        else $error("signed stream level wrong");
    a_mode0_holds: assert property (@(posedge clk_i) disable iff (rst_i)
        mode == HMTC_M_INTERNAL && !req_i.wr && !soft_reset |=> launch == $past(launch))
        else $error("launch moved without software in mode 0");
    a_standby_default: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(soft_reset) |-> standby && !launch)
        else $error("standby not set after soft reset");
    a_cancel_stops: assert property (@(posedge clk_i) disable iff (rst_i)
        cancel |-> !launch)
        else $error("cancel left launch set");
    c_edge_cancel: cover property (@(posedge clk_i) mode == HMTC_M_EDGE && pin_rise && launch);
    c_routine_fail: cover property (@(posedge clk_i) routine_done && routine_fail_i);
    c_soft_reset: cover property (@(posedge clk_i) $fell(soft_reset));
    c_level_cancel: cover property (@(posedge clk_i) mode == HMTC_M_LEVEL && pin_fall && launch);
endmodule : hmtc_top

// ===== bench/hmtc_host_model.sv
// host side partner: register strobes on the control bus plus the stimulus pin and routine result line
module hmtc_host_model
    import hmtc_pkg::*;
(
    input wire logic clk_i,
    output hmtc_pkg::hmtc_req_t req_o,
    output logic pin_o,
    output logic fail_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        req_o = '0;
        pin_o = 1'b0;
        fail_o = 1'b0;
    end

    // one-cycle strobe, taken at the edge that ends the task; back-to-back calls leave one idle cycle
    task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk_i);
        req_o <= '{wr: wr, rd: !wr, addr: addr, wdata: data};
        @(posedge clk_i);
        req_o <= '0;
    endtask : access

    // result line is set before the launch so the routine never samples a stale value
    task automatic drive_lines(input logic pin, input logic fail);
        @(posedge clk_i);
        pin_o <= pin;
        fail_o <= fail;
    endtask : drive_lines
endmodule : hmtc_host_model

// ===== bench/test_haptic_mode_trigger_control.sv
// self-checking bench for the mode-control block
module test_haptic_mode_trigger_control;
    timeunit 1ns;
    timeprecision 1ps;
    import hmtc_pkg::*;

    logic clk = 1'b0;
    logic rst = 1'b1;
    hmtc_req_t req;
    logic pin, fail, launch, cancel, standby, busy;
    logic [7:0] rdata, v, a, ic;
    logic f, u;
    hmtc_drive_t drive;
    int mismatches = 0;
    int compares = 0;
    int cancels = 0;
    int n, c0;

    always #5 clk = ~clk;

    always @(posedge clk) begin
        if (cancel === 1'b1) begin
            cancels <= cancels + 1;
        end
    end

    hmtc_host_model u_host (.clk_i(clk), .req_o(req), .pin_o(pin), .fail_o(fail));

    hmtc_top u_dut (
        .clk_i(clk), .rst_i(rst), .req_i(req), .shared_stimulus_pin_i(pin), .routine_fail_i(fail),
        .rdata_o(rdata), .launch_o(launch), .cancel_o(cancel), .standby_o(standby),
        .routine_busy_o(busy), .drive_o(drive)
    );

    task automatic end_of_test();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        u_host.access(1'b1, addr, data);
        #1;
    endtask : wr

    // sampled one edge late on purpose: read data holds until the next read or a soft reset
    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        u_host.access(1'b0, addr, 8'h00);
        @(posedge clk);
        #1;
        data = rdata;
    endtask : rd

    task automatic wait_launch(input logic lvl, output int cnt);
        cnt = 0;
        while (launch !== lvl && cnt < 64) begin
            @(posedge clk);
            #1;
            cnt++;
        end
        if (launch !== lvl) begin
            mismatches++;
            $display("CHECK FAILED at %0t: launch wait timed out", $time);
            end_of_test();
        end
    endtask : wait_launch

    function automatic logic [8:0] exp_level(input logic [7:0] amp, input logic unsig);
        return unsig ? {1'b0, amp} : {amp[7], amp};
    endfunction : exp_level

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        $display("CHECK FAILED at %0t: run timed out", $time);
        end_of_test();
    end

    initial begin
        void'($urandom(32'h70d3));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        check({rdata, launch, cancel, standby, busy}, 12'h002, "reset outputs");
        check(16'(drive), 16'h0000, "reset drive");
        rd(OFF_MODE, v);
        check(v, MODE_RESET, "mode reset");
        rd(OFF_STATUS, v);
        check(v, {DEVICE_CODE, 5'h00}, "status reset");
        rd(8'h7f, v);
        check(v, 8'h00, "unmapped read");
        // software launch only; pin ignored in mode 0
        wr(OFF_MODE, 8'h00);
        check(standby, 1'b0, "standby clear");
        u_host.drive_lines(1'b1, 1'b0);
        repeat (8) @(posedge clk);
        #1;
        check(launch, 1'b0, "pin in mode 0");
        u_host.drive_lines(1'b0, 1'b0);
        wr(OFF_LAUNCH, 8'h01);
        check(launch, 1'b1, "software launch");
        wr(OFF_LAUNCH, 8'h00);
        // edge trigger: second rise cancels
        wr(OFF_MODE, 8'h01);
        c0 = cancels;
        u_host.drive_lines(1'b1, 1'b0);
        wait_launch(1'b1, n);
        u_host.drive_lines(1'b0, 1'b0);
        repeat (4) @(posedge clk);
        u_host.drive_lines(1'b1, 1'b0);
        wait_launch(1'b0, n);
        repeat (2) @(posedge clk);
        check(16'(cancels - c0), 16'h0001, "edge cancel");
        u_host.drive_lines(1'b0, 1'b0);
        // level trigger on code 2
        wr(OFF_MODE, 8'h02);
        c0 = cancels;
        u_host.drive_lines(1'b1, 1'b0);
        wait_launch(1'b1, n);
        u_host.drive_lines(1'b0, 1'b0);
        wait_launch(1'b0, n);
        repeat (2) @(posedge clk);
        check(16'(cancels - c0), 16'h0001, "level cancel");
        wr(OFF_LAUNCH, 8'h01);
        c0 = cancels;
        u_host.drive_lines(1'b1, 1'b0);
        repeat (8) @(posedge clk);
        #1;
        check({launch, 16'(cancels - c0)}, 17'h10000, "redundant edge");
        u_host.drive_lines(1'b0, 1'b0);
        wait_launch(1'b0, n);
        // pin-driven modes
        for (int m = 3; m <= 4; m++) begin
            ic = (m == 4) ? 8'h03 : {7'h00, 1'($urandom)};
            wr(OFF_INCTL, ic);
            wr(OFF_MODE, 8'(m));
            repeat (2) @(posedge clk);
            #1;
            check({drive.active, drive.use_pin, drive.analog, drive.audio}, {2'b11, ic[0], m == 4},
                  "pin drive");
        end
        // streamed amplitude, both formats, sign boundary first, then one forced unsigned value
        wr(OFF_MODE, 8'h05);
        for (int i = 0; i < 8; i++) begin
            a = (i == 0) ? 8'h80 : (i == 1) ? 8'h7f : 8'($urandom);
            u = (i < 2) ? 1'b0 : (i == 2) ? 1'b1 : 1'($urandom);
            wr(OFF_FORMAT, {4'h0, u, 3'h0});
            wr(OFF_AMPL, a);
            repeat (2) @(posedge clk);
            #1;
            check({drive.active, drive.stream, drive.level}, {2'b11, exp_level(a, u)}, "stream");
        end
        // diagnostic and calibration routines
        for (int i = 0; i < 4; i++) begin
            f = (i < 2) ? i[0] : 1'($urandom);
            wr(OFF_MODE, (i % 2 == 0) ? 8'h06 : 8'h07);
            u_host.drive_lines(1'b0, f);
            wr(OFF_LAUNCH, 8'h01);
            check({launch, busy}, 2'b11, "routine start");
            wait_launch(1'b0, n);
            check({16'(n), busy}, {16'(ROUTINE_CYCLES), 1'b0}, "routine length");
            rd(OFF_STATUS, v);
            check(v[3], f, "outcome");
            rd(OFF_STATUS, v);
            check(v[3], 1'b0, "outcome cleared on read");
        end
        // soft reset mid-playback; a write inside the reset window is dropped
        wr(OFF_MODE, 8'h05);
        wr(OFF_AMPL, 8'h5a);
        wr(OFF_LAUNCH, 8'h01);
        c0 = cancels;
        wr(OFF_MODE, 8'h85);
        check(launch, 1'b0, "playback stopped");
        wr(OFF_AMPL, 8'h33);
        repeat (6) @(posedge clk);
        rd(OFF_MODE, v);
        check(v, MODE_RESET, "mode after soft reset");
        rd(OFF_AMPL, v);
        check(v, AMPL_RESET, "amplitude after soft reset");
        check(16'(cancels - c0), 16'h0001, "soft reset cancel");
        check({standby, 16'(drive)}, 17'h10000, "outputs after soft reset");
        end_of_test();
    end
endmodule : test_haptic_mode_trigger_control
